/* File: core/swd_defines.svh */
`ifndef SWD_DEFINES_SVH
`define SWD_DEFINES_SVH
// How it works
// RULE_01: Open or pulled-up config pin gives fixed timeouts, a cap gives a formula.
// RULE_02: Open pin, select high: timeout 1360/1600/1840 ms.
// RULE_03: Pulled-up pin, select high: timeout 170/200/230 ms.
// RULE_04: Cap mode typical timeout is 77.4 ms per nF plus 55 ms.
// RULE_05: Cap mode min is 0.905 and max is 1.095 of the typical.
// RULE_06: The timing cap must lie between 100 pF and 1 uF; the CAP register takes any value from 0 to 16383 in 100 pF steps, unchecked.
// RULE_07: The host kicks before the minimum timeout runs out.
// RULE_08: A kick interval beyond the maximum timeout drives the fault low.
// RULE_09: After a fault, a timely kick releases the fault output.
// RULE_10: Select low disables the watchdog and ignores kicks.
// RULE_11: Only falling kick edges count; intervals run edge to edge.
// RULE_12: Select rising starts a 150 us setup that ignores kicks.
// RULE_13: Gate low ignores kicks, releases fault, drives the echo low.
// RULE_14: The config mode is caught once after reset; timeouts are counts.
// RULE_15: Each kick restarts the count; after a fault, counting resumes on a kick.

// ****************************************
// Timebase and timing
// ****************************************
`define SWD_CLK_MHZ       40
`define SWD_NC_MIN_MS     1360
`define SWD_NC_MAX_MS     1840
`define SWD_PU_MIN_MS     170
`define SWD_PU_MAX_MS     230
`define SWD_NC_MIN_CYC    (`SWD_NC_MIN_MS * `SWD_CLK_MHZ * 1000)
`define SWD_NC_MAX_CYC    (`SWD_NC_MAX_MS * `SWD_CLK_MHZ * 1000)
`define SWD_PU_MIN_CYC    (`SWD_PU_MIN_MS * `SWD_CLK_MHZ * 1000)
`define SWD_PU_MAX_CYC    (`SWD_PU_MAX_MS * `SWD_CLK_MHZ * 1000)
`define SWD_SETUP_US      150
`define SWD_SETUP_CYC     (`SWD_SETUP_US * `SWD_CLK_MHZ)
`define SWD_CAP_SLOPE_US  7740
`define SWD_CAP_OFFS_US   55000
`define SWD_MIN_PERMILLE  905
`define SWD_MAX_PERMILLE  1095

// ****************************************
// Register map and fields
// ****************************************
`define SWD_REG_STATUS    8'h00
`define SWD_REG_CAP       8'h04
`define SWD_REG_IRQ_STAT  8'h08
`define SWD_REG_IRQ_MASK  8'h0c
`define SWD_REG_COUNT     8'h10
`define SWD_REG_LIM_MAX   8'h14
`define SWD_REG_LIM_MIN   8'h18
`define SWD_CAP_W         14
`define SWD_CAP_RST       14'h000a
`define SWD_IRQ_W         3
`define SWD_IRQ_FAULT     0
`define SWD_IRQ_KICK      1
`define SWD_IRQ_RUN       2
`define SWD_MASK_RST      3'h0
`define SWD_RESP_OKAY     2'h0
`define SWD_RESP_SLVERR   2'h2
`endif

/* File: core/swd_pkg.sv */
package swd_pkg;

  // Config pin reading; code 2'h3 is treated as open
  typedef enum logic [1:0]
  {
    SWD_CFG_OPEN   = 2'h0,
    SWD_CFG_PULLUP = 2'h1,
    SWD_CFG_CAP    = 2'h2
  } swd_cfg_t;

  // Gray order along off, setup, run, fault
  typedef enum logic [1:0]
  {
    SWD_OFF   = 2'h0,
    SWD_SETUP = 2'h1,
    SWD_RUN   = 2'h3,
    SWD_FAULT = 2'h2
  } swd_state_t;

  typedef struct packed
  {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } swd_axi_req_t;

  typedef struct packed
  {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } swd_axi_rsp_t;

endpackage

/* File: core/swd_top.sv */
`timescale 1ns/100ps
`include "swd_defines.svh"
module swd_top #(
  parameter logic [31:0] NC_MIN_CYC = `SWD_NC_MIN_CYC,
  parameter logic [31:0] NC_MAX_CYC = `SWD_NC_MAX_CYC,
  parameter logic [31:0] PU_MIN_CYC = `SWD_PU_MIN_CYC,
  parameter logic [31:0] PU_MAX_CYC = `SWD_PU_MAX_CYC,
  parameter logic [31:0] SETUP_CYC  = `SWD_SETUP_CYC
) (
  input  wire logic                  mclk_in,               // 40 MHz
  input  wire logic                  nrst_in,               // Async reset
  input  wire swd_pkg::swd_axi_req_t axi_in,                // Bus request
  output swd_pkg::swd_axi_rsp_t      axi_out,               // Bus answer
  input  wire logic [1:0]            timeout_config_pin_in, // Mode code
  input  wire logic                  watchdog_select_pin_in,// Enable
  input  wire logic                  gate_in,               // Gate input
  input  wire logic                  kick_input_in,         // Kick
  output logic                       fault_output_n_out,    // Low = fault
  output logic                       fault_output_oe_out,   // Drives low
  output logic                       gate_echo_output_out,  // Gate echo
  output logic                       irq_out                // Interrupt
);

  // ****************************************
  // Parameter checks
  // ****************************************
  if (NC_MAX_CYC == 32'h0 || PU_MAX_CYC == 32'h0 || SETUP_CYC == 32'h0)
  begin : g_chk
    $error("swd_top: timing counts must be nonzero");
  end

  // ****************************************
  // Helper functions
  // ****************************************
  // Cap timeout in cycles; min rounds up, max rounds down
  function automatic logic [31:0] swd_cap_cyc(
    input logic [`SWD_CAP_W-1:0] cap,
    input logic [10:0]           permille,
    input logic                  up
  );
    logic [47:0] t;
    t = (48'(cap) * 48'(`SWD_CAP_SLOPE_US) + 48'(`SWD_CAP_OFFS_US))
        * 48'(`SWD_CLK_MHZ) * 48'(permille);
    if (up)
      t = t + 48'd999;
    return 32'(t / 48'd1000);
  endfunction

  // Known word addresses
  function automatic logic swd_mapped(input logic [7:0] a);
    return a == `SWD_REG_STATUS || a == `SWD_REG_CAP ||
           a == `SWD_REG_IRQ_STAT || a == `SWD_REG_IRQ_MASK ||
           a == `SWD_REG_COUNT || a == `SWD_REG_LIM_MAX ||
           a == `SWD_REG_LIM_MIN;
  endfunction

  // Byte lane merge
  function automatic logic [31:0] swd_merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  // ****************************************
  // State
  // ****************************************
  swd_pkg::swd_state_t          state_ff;
  logic [31:0]                  cnt_ff;
  logic [1:0]                   mode_ff;
  logic                         mode_done_ff;
  logic                         setup_pend_ff;
  logic                         kick_d_ff;
  logic                         fault_ff;
  logic                         echo_ff;
  logic [`SWD_CAP_W-1:0]        cap_ff;
  logic [`SWD_IRQ_W-1:0]        irq_stat_ff;
  logic [`SWD_IRQ_W-1:0]        irq_mask_ff;
  logic                         aw_got_ff;
  logic                         w_got_ff;
  logic [7:0]                   awaddr_ff;
  logic [31:0]                  wdata_ff;
  logic [3:0]                   wstrb_ff;
  logic                         bvalid_ff;
  logic [1:0]                   bresp_ff;
  logic                         rvalid_ff;
  logic [31:0]                  rdata_ff;
  logic [1:0]                   rresp_ff;

  // ****************************************
  // Mode and timeout limits
  // ****************************************
  // Pin code 2'h3 has no meaning, so it falls back to the long timeout
  wire logic [1:0] nxt_mode =
    (timeout_config_pin_in == swd_pkg::SWD_CFG_PULLUP) ? 2'h1 :
    (timeout_config_pin_in == swd_pkg::SWD_CFG_CAP)    ? 2'h2 : 2'h0;
  wire logic is_pu  = mode_ff == swd_pkg::SWD_CFG_PULLUP;
  wire logic is_cap = mode_ff == swd_pkg::SWD_CFG_CAP;
  wire logic [31:0] cap_max =
    swd_cap_cyc(cap_ff, 11'(`SWD_MAX_PERMILLE), 1'b0); // RULE_04 RULE_05
  wire logic [31:0] cap_min =
    swd_cap_cyc(cap_ff, 11'(`SWD_MIN_PERMILLE), 1'b1); // RULE_05
  wire logic [31:0] lim_max =
    is_cap ? cap_max : is_pu ? PU_MAX_CYC : NC_MAX_CYC; // RULE_01 RULE_02
  wire logic [31:0] lim_min =
    is_cap ? cap_min : is_pu ? PU_MIN_CYC : NC_MIN_CYC; // RULE_03

  // Caught once, after the reset release
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      mode_ff      <= 2'h0;
      mode_done_ff <= 1'b0;
    end
    else if (!mode_done_ff)
    begin
      mode_ff      <= nxt_mode; // RULE_14
      mode_done_ff <= 1'b1;
    end
  end

  // ****************************************
  // Watchdog sequencer
  // ****************************************
  wire logic active    = watchdog_select_pin_in & gate_in & mode_done_ff;
  wire logic kick_fall = kick_d_ff & ~kick_input_in; // RULE_11
  wire logic in_run    = state_ff == swd_pkg::SWD_RUN;
  wire logic in_fault  = state_ff == swd_pkg::SWD_FAULT;
  wire logic in_setup  = state_ff == swd_pkg::SWD_SETUP;
  // Setup and off states drop kicks
  wire logic kick_acc  = active & kick_fall & (in_run | in_fault);
  wire logic setup_end = in_setup & (cnt_ff == SETUP_CYC - 32'h1);
  // Kick in the last cycle still wins over the timeout
  wire logic expire    = in_run & ~kick_acc & (cnt_ff == lim_max - 32'h1);

  swd_pkg::swd_state_t nxt_state;
  logic [31:0]         nxt_cnt;
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    if (!active)
    begin
      nxt_state = swd_pkg::SWD_OFF; // RULE_10 RULE_13
      nxt_cnt   = 32'h0;
    end
    else
    begin
      unique case (state_ff)
        swd_pkg::SWD_OFF:
        begin
          nxt_state = setup_pend_ff ? swd_pkg::SWD_SETUP : swd_pkg::SWD_RUN;
          nxt_cnt   = 32'h0;
        end
        swd_pkg::SWD_SETUP:
        begin
          nxt_state = setup_end ? swd_pkg::SWD_RUN : swd_pkg::SWD_SETUP;
          nxt_cnt   = setup_end ? 32'h0 : cnt_ff + 32'h1; // RULE_12
        end
        swd_pkg::SWD_RUN:
        begin
          if (kick_acc)
            nxt_cnt = 32'h0; // RULE_15
          else if (expire)
          begin
            nxt_state = swd_pkg::SWD_FAULT; // RULE_08
            nxt_cnt   = 32'h0;
          end
          else
            nxt_cnt = cnt_ff + 32'h1;
        end
        swd_pkg::SWD_FAULT:
        begin
          // Count stays idle until a kick comes back
          if (kick_acc)
            nxt_state = swd_pkg::SWD_RUN; // RULE_09 RULE_15
          nxt_cnt = 32'h0;
        end
      endcase
    end
  end

  // Select low arms a fresh setup for the next enable
  wire logic nxt_pend = ~watchdog_select_pin_in |
                        (setup_pend_ff & ~setup_end); // RULE_12

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_ff      <= swd_pkg::SWD_OFF;
      cnt_ff        <= 32'h0;
      setup_pend_ff <= 1'b1;
      kick_d_ff     <= 1'b0;
      fault_ff      <= 1'b0;
      echo_ff       <= 1'b0;
    end
    else
    begin
      state_ff      <= nxt_state;
      cnt_ff        <= nxt_cnt;
      setup_pend_ff <= nxt_pend;
      kick_d_ff     <= kick_input_in;
      fault_ff      <= nxt_state == swd_pkg::SWD_FAULT;
      echo_ff       <= gate_in; // RULE_13
    end
  end

  assign fault_output_n_out   = ~fault_ff;
  assign fault_output_oe_out  = fault_ff;
  assign gate_echo_output_out = echo_ff;

  // ****************************************
  // Interrupts
  // ****************************************
  wire logic [`SWD_IRQ_W-1:0] irq_ev = {
    in_setup & setup_end & active,
    kick_acc,
    expire & active
  };
  wire logic do_wr = aw_got_ff & w_got_ff & ~bvalid_ff;
  wire logic wr_ok = do_wr & swd_mapped(awaddr_ff);
  wire logic [`SWD_IRQ_W-1:0] irq_clr =
    (wr_ok && awaddr_ff == `SWD_REG_IRQ_STAT && wstrb_ff[0]) ?
    wdata_ff[`SWD_IRQ_W-1:0] : '0;
  // Set beats clear, so an event in the clearing cycle stays seen
  wire logic [`SWD_IRQ_W-1:0] nxt_irq_stat =
    (irq_stat_ff & ~irq_clr) | irq_ev;
  wire logic [31:0] nxt_cap = swd_merge(32'(cap_ff), wdata_ff, wstrb_ff);
  wire logic [31:0] nxt_mask =
    swd_merge(32'(irq_mask_ff), wdata_ff, wstrb_ff);
  assign irq_out = |(irq_stat_ff & irq_mask_ff);

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  wire logic aw_hs = axi_in.awvalid & ~aw_got_ff & ~bvalid_ff;
  wire logic w_hs  = axi_in.wvalid & ~w_got_ff & ~bvalid_ff;
  wire logic ar_hs = axi_in.arvalid & ~rvalid_ff;
  wire logic [31:0] rd_word =
    (axi_in.araddr == `SWD_REG_STATUS)   ?
      {26'h0, mode_ff, setup_pend_ff, in_setup, in_run, fault_ff} :
    (axi_in.araddr == `SWD_REG_CAP)      ? 32'(cap_ff) :
    (axi_in.araddr == `SWD_REG_IRQ_STAT) ? 32'(irq_stat_ff) :
    (axi_in.araddr == `SWD_REG_IRQ_MASK) ? 32'(irq_mask_ff) :
    (axi_in.araddr == `SWD_REG_COUNT)    ? cnt_ff :
    (axi_in.araddr == `SWD_REG_LIM_MAX)  ? lim_max :
    (axi_in.araddr == `SWD_REG_LIM_MIN)  ? lim_min : 32'h0;

  // Write channels are latched separately, then applied together
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 8'h0;
      wdata_ff  <= 32'h0;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= `SWD_RESP_OKAY;
    end
    else
    begin
      aw_got_ff <= (aw_got_ff | aw_hs) & ~do_wr;
      w_got_ff  <= (w_got_ff | w_hs) & ~do_wr;
      if (aw_hs)
        awaddr_ff <= axi_in.awaddr;
      if (w_hs)
      begin
        wdata_ff <= axi_in.wdata;
        wstrb_ff <= axi_in.wstrb;
      end
      bvalid_ff <= do_wr | (bvalid_ff & ~axi_in.bready);
      if (do_wr)
        bresp_ff <= wr_ok ? `SWD_RESP_OKAY : `SWD_RESP_SLVERR;
    end
  end

  // Register updates
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cap_ff      <= `SWD_CAP_RST;
      irq_mask_ff <= `SWD_MASK_RST;
      irq_stat_ff <= '0;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      if (wr_ok && awaddr_ff == `SWD_REG_CAP)
        cap_ff <= nxt_cap[`SWD_CAP_W-1:0];
      if (wr_ok && awaddr_ff == `SWD_REG_IRQ_MASK)
        irq_mask_ff <= nxt_mask[`SWD_IRQ_W-1:0];
    end
  end

  // Read answers one cycle after the address is taken
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rresp_ff  <= `SWD_RESP_OKAY;
    end
    else
    begin
      rvalid_ff <= ar_hs | (rvalid_ff & ~axi_in.rready);
      if (ar_hs)
      begin
        rdata_ff <= rd_word;
        rresp_ff <= swd_mapped(axi_in.araddr) ?
                    `SWD_RESP_OKAY : `SWD_RESP_SLVERR;
      end
    end
  end

  assign axi_out.awready = ~aw_got_ff & ~bvalid_ff;
  assign axi_out.wready  = ~w_got_ff & ~bvalid_ff;
  assign axi_out.bvalid  = bvalid_ff;
  assign axi_out.bresp   = bresp_ff;
  assign axi_out.arready = ~rvalid_ff;
  assign axi_out.rvalid  = rvalid_ff;
  assign axi_out.rdata   = rdata_ff;
  assign axi_out.rresp   = rresp_ff;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_fault_kick;
    in_fault ##0 kick_acc;
  endsequence
  sequence s_run_last;
    in_run && cnt_ff == lim_max - 32'h1 && !kick_acc && active;
  endsequence

  nc_limit_a: assert property (mode_done_ff && !is_pu && !is_cap |->
    lim_max == NC_MAX_CYC && lim_min == NC_MIN_CYC) // RULE_02
    else $error("open pin limits wrong");
  pu_limit_a: assert property (is_pu |->
    lim_max == PU_MAX_CYC && lim_min == PU_MIN_CYC) // RULE_03
    else $error("pull-up limits wrong");
  cap_limit_a: assert property (is_cap && cap_ff == 14'h000a |->
    lim_max == 32'd5799120 && lim_min == 32'd4792880) // RULE_04
    else $error("1 nF cap limits wrong");
  timeout_a: assert property (s_run_last |=> in_fault ##0 !fault_output_n_out
    ) // RULE_08
    else $error("missed timeout fault");
  release_a: assert property (s_fault_kick |=> in_run && cnt_ff == 32'h0
    && fault_output_n_out) // RULE_09
    else $error("fault not released by kick");
  kick_restart_a: assert property (kick_acc && active |=>
    cnt_ff == 32'h0 && !fault_ff) // RULE_15
    else $error("kick did not restart count");
  select_off_a: assert property (!watchdog_select_pin_in |=>
    state_ff == swd_pkg::SWD_OFF && fault_output_n_out) // RULE_10
    else $error("watchdog active while deselected");
  setup_len_a: assert property (in_setup |-> cnt_ff < SETUP_CYC &&
    !kick_acc) // RULE_12
    else $error("setup window broken");
  gate_low_a: assert property (!gate_in |=> !gate_echo_output_out &&
    fault_output_n_out && !in_run) // RULE_13
    else $error("gate low not honoured");
  mode_hold_a: assert property (mode_done_ff |=> $stable(mode_ff)) // RULE_14
    else $error("mode changed after capture");
  irq_level_a: assert property (irq_ev[`SWD_IRQ_FAULT] |=> // RULE_08
    irq_stat_ff[`SWD_IRQ_FAULT])
    else $error("fault event not latched");

endmodule

/* File: tb/swd_host_model.sv */
`timescale 1ns/100ps
// ****************************************
// Host side that kicks the watchdog
// ****************************************
module swd_host_model (
  input  wire logic        mclk_in,   // Bench clock
  input  wire logic        run_in,    // Kick while high
  input  wire logic [15:0] period_in, // Cycles per kick
  output logic             kick_out   // Kick line
);
  logic [15:0] cnt;

  initial
  begin
    cnt = 16'h0000;
    kick_out = 1'b1;
  end

  // One falling edge per period; idle high, so a stop gives only a rise
  always @(posedge mclk_in)
  begin
    if (!run_in)
    begin
      cnt <= 16'h0000;
      kick_out <= 1'b1;
    end
    else
    begin
      cnt <= (cnt + 16'h0001 >= period_in) ? 16'h0000 : cnt + 16'h0001;
      kick_out <= (cnt < (period_in >> 1));
    end
  end
endmodule

/* File: tb/test_strap_configured_watchdog.sv */
`timescale 1ns/100ps
`include "swd_defines.svh"
module test_strap_configured_watchdog;
  localparam logic [31:0] NCX = 32'h0000_00c8; // Shortened open-pin max
  localparam logic [31:0] NCN = 32'h0000_0096;
  localparam logic [31:0] PUX = 32'h0000_0032;
  localparam logic [31:0] PUN = 32'h0000_0028;
  localparam logic [31:0] SU  = 32'h0000_000a;
  logic                  mclk_in, nrst_in, sel, gate, run, kick, kick_q;
  logic                  fault_n, oe, echo, irq;
  logic [1:0]            cfg, resp;
  logic [15:0]           per;
  logic [31:0]           rd;
  swd_pkg::swd_axi_req_t req;
  swd_pkg::swd_axi_rsp_t rsp;
  int                    checks, bad_count, cyc, last_fall, at, mark, n;

  swd_top #(.NC_MIN_CYC(NCN), .NC_MAX_CYC(NCX), .PU_MIN_CYC(PUN),
    .PU_MAX_CYC(PUX), .SETUP_CYC(SU)) u_dut (.mclk_in(mclk_in),
    .nrst_in(nrst_in), .axi_in(req), .axi_out(rsp),
    .timeout_config_pin_in(cfg), .watchdog_select_pin_in(sel),
    .gate_in(gate), .kick_input_in(kick), .fault_output_n_out(fault_n),
    .fault_output_oe_out(oe), .gate_echo_output_out(echo), .irq_out(irq));
  swd_host_model u_host (.mclk_in(mclk_in), .run_in(run),
    .period_in(per), .kick_out(kick));

  // Clock and the cycle of the last falling kick edge
  initial
  begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    kick_q <= kick;
    if (kick_q && !kick) last_fall <= cyc;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // Timing has a small latency slack, never a missing or early event
  task automatic near(string nm, int got, int lo);
    check(nm, 32'(got >= lo && got <= lo + 4), 32'h1);
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask
  // Counts cycles with the fault output low
  task automatic quiet(int k);
    n = 0;
    repeat (k)
    begin
      tick(1);
      if (fault_n !== 1'b1) n++;
    end
  endtask
  task automatic wait_fault;
    n = 0;
    while (fault_n !== 1'b0 && n < 2000)
    begin
      tick(1);
      n++;
    end
    at = cyc;
  endtask
  task automatic do_reset(logic [1:0] c);
    @(posedge mclk_in);
    cfg <= c;
    nrst_in <= 1'b0;
    repeat (6) @(posedge mclk_in);
    nrst_in <= 1'b1;
    tick(2);
  endtask
  // Bus write: address and data offered together, each dropped when taken
  task automatic axi_wr(logic [7:0] a, logic [31:0] d);
    logic ta, tw, tb;
    @(posedge mclk_in);
    n = 0;
    tb = 1'b0;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!tb && n < 50)
    begin
      @(negedge mclk_in);
      ta = req.awvalid && rsp.awready;
      tw = req.wvalid && rsp.wready;
      tb = req.bready && rsp.bvalid;
      resp = rsp.bresp;
      @(posedge mclk_in);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      n++;
    end
    req.bready <= 1'b0;
    if (!tb) bad_count++;
  endtask
  task automatic axi_rd(logic [7:0] a);
    logic ta, tr;
    @(posedge mclk_in);
    n = 0;
    tr = 1'b0;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    while (!tr && n < 50)
    begin
      @(negedge mclk_in);
      ta = req.arvalid && rsp.arready;
      tr = req.rready && rsp.rvalid;
      rd = rsp.rdata;
      resp = rsp.rresp;
      @(posedge mclk_in);
      if (ta) req.arvalid <= 1'b0;
      n++;
    end
    req.rready <= 1'b0;
    if (!tr) bad_count++;
  endtask
  task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] e);
    axi_rd(a);
    check(nm, rd, e);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard, far beyond the few thousand cycles of the tests
  initial
  begin
    #(25 * 60000);
    bad_count++;
    give_verdict;
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    checks = 0;
    bad_count = 0;
    cyc = 0;
    last_fall = 0;
    kick_q = 1'b1;
    req = '0;
    sel = 1'b1;
    gate = 1'b1;
    run = 1'b0;
    per = 16'h0064;
    cfg = 2'h0;
    nrst_in = 1'b0;
    do_reset(2'h0);
    check("fault_n", 32'(fault_n), 32'h1);
    check("echo", 32'(echo), 32'h1);
    axi_rd(`SWD_REG_STATUS);
    check("mode", 32'(rd[5:4]), 32'h0);
    rd_chk("lim_max", `SWD_REG_LIM_MAX, NCX);
    rd_chk("lim_min", `SWD_REG_LIM_MIN, NCN);
    rd_chk("cap", `SWD_REG_CAP, 32'(`SWD_CAP_RST));
    rd_chk("mask", `SWD_REG_IRQ_MASK, 32'h0);
    rd_chk("unmapped", 8'h1c, 32'h0);
    check("rd_resp", 32'(resp), 32'(`SWD_RESP_SLVERR));
    axi_wr(8'h1c, 32'h1);
    check("wr_resp", 32'(resp), 32'(`SWD_RESP_SLVERR));
    $display("test registers done");
    run <= 1'b1;
    quiet(800);
    check("early_kicks", 32'(n), 32'h0);
    axi_rd(`SWD_REG_IRQ_STAT);
    check("kick_evt", 32'(rd[2:1]), 32'h3);
    run <= 1'b0;
    wait_fault;
    near("timeout", at - last_fall, NCX);
    check("oe", 32'(oe), 32'h1);
    rd_chk("count_idle", `SWD_REG_COUNT, 32'h0);
    axi_rd(`SWD_REG_STATUS);
    check("stat_fault", 32'(rd[1:0]), 32'h1);
    check("irq_masked", 32'(irq), 32'h0);
    axi_wr(`SWD_REG_IRQ_MASK, 32'h1);
    tick(2);
    check("irq_on", 32'(irq), 32'h1);
    axi_wr(`SWD_REG_IRQ_STAT, 32'h7);
    tick(2);
    check("irq_clr", 32'(irq), 32'h0);
    $display("test timeout done");
    run <= 1'b1;
    tick(110);
    check("release", 32'(fault_n), 32'h1);
    quiet(300);
    check("resumed", 32'(n), 32'h0);
    $display("test recovery done");
    gate <= 1'b0;
    run <= 1'b0;
    tick(2);
    check("echo_low", 32'(echo), 32'h0);
    quiet(400);
    check("gated", 32'(n), 32'h0);
    gate <= 1'b1;
    mark = cyc;
    wait_fault;
    near("ungate", at - mark, NCX);
    sel <= 1'b0;
    tick(2);
    check("sel_rel", 32'(fault_n), 32'h1);
    per <= 16'h0008;
    run <= 1'b1;
    quiet(400);
    check("disabled", 32'(n), 32'h0);
    run <= 1'b0;
    tick(2);
    sel <= 1'b1;
    run <= 1'b1;
    mark = cyc;
    tick(6);
    run <= 1'b0;
    wait_fault;
    near("setup", at - mark, SU + NCX);
    $display("test gating done");
    do_reset(2'h1);
    axi_rd(`SWD_REG_STATUS);
    check("mode_pu", 32'(rd[5:4]), 32'h1);
    rd_chk("pu_max", `SWD_REG_LIM_MAX, PUX);
    rd_chk("pu_min", `SWD_REG_LIM_MIN, PUN);
    per <= 16'h001e;
    run <= 1'b1;
    quiet(200);
    check("pu_kicks", 32'(n), 32'h0);
    run <= 1'b0;
    wait_fault;
    near("pu_timeout", at - last_fall, PUX);
    do_reset(2'h2);
    rd_chk("cap_max", `SWD_REG_LIM_MAX, 32'd5799120);
    rd_chk("cap_min", `SWD_REG_LIM_MIN, 32'd4792880);
    axi_wr(`SWD_REG_CAP, 32'h14);
    rd_chk("cap2_max", `SWD_REG_LIM_MAX, 32'd9189240);
    rd_chk("cap2_min", `SWD_REG_LIM_MIN, 32'd7594760);
    do_reset(2'h3);
    rd_chk("open3_max", `SWD_REG_LIM_MAX, NCX);
    $display("test modes done");
    give_verdict;
  end
endmodule
